// [design/lbc_defines.svh]
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH
`define LBC_OP_AND 6'h09
`define LBC_OP_BIT_CLEAR 6'h0F
`define LBC_SIGN_BIT 31
`define LBC_FLAGS_RESET 3'h0
`endif

// [design/lbc_pkg.sv]
package lbc_pkg;
  typedef enum logic [1:0] {
    LBC_IDLE = 2'b00,
    LBC_EXEC = 2'b01,
    LBC_WRITE = 2'b10
  } lbc_phase_e;

  typedef struct packed {
    logic z;
    logic n;
    logic c;
  } lbc_flags_s;

  // Instruction issue from the decoder
  typedef struct packed {
    logic [5:0] opcode;
    logic [4:0] src_field;
    logic [4:0] dst_field;
  } lbc_instr_s;

  // Register file read request
  typedef struct packed {
    logic src_en;
    logic dst_en;
    logic [4:0] src_addr;
    logic [4:0] dst_addr;
  } lbc_rd_s;

  // Register file write back
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [31:0] data;
  } lbc_wr_s;

  typedef struct packed {
    lbc_phase_e phase;
    logic is_and;
    logic [4:0] src_field;
    logic [4:0] dst_field;
    logic [31:0] src_val;
    logic [31:0] dst_val;
    lbc_wr_s wr;
    lbc_flags_s flags;
  } lbc_state_s;
endpackage

// [design/lbc_alu.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lbc_defines.svh"
module lbc_alu #(
  parameter int DATA_W = 32,
  parameter int IDX_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire lbc_pkg::lbc_instr_s issue,
  output logic issue_ready,
  output lbc_pkg::lbc_rd_s rd_req,
  input wire logic [31:0] rd_src_data,
  input wire logic [31:0] rd_dst_data,
  output lbc_pkg::lbc_wr_s wr,
  output lbc_pkg::lbc_flags_s flags,
  output logic busy
);
  import lbc_pkg::*;

  // ==========================================================
  // Local constants
  // ==========================================================
  localparam logic [5:0] OP_AND = `LBC_OP_AND;
  localparam logic [5:0] OP_BIT_CLEAR = `LBC_OP_BIT_CLEAR;
  localparam int SIGN_BIT = `LBC_SIGN_BIT;

  // ==========================================================
  // Elaboration checks
  // ==========================================================
  // Port structs fix the widths; only the documented sizes are served
  if (DATA_W != 32) begin : g_bad_data_w
    $error("lbc_alu: DATA_W must be 32");
  end

  if ((1 << IDX_W) != DATA_W) begin : g_bad_idx_w
    $error("lbc_alu: IDX_W must address every bit of DATA_W");
  end

  if (SIGN_BIT != DATA_W - 1) begin : g_bad_sign
    $error("lbc_alu: sign bit must be the top bit");
  end

  if (OP_AND == OP_BIT_CLEAR) begin : g_bad_ops
    $error("lbc_alu: opcodes must differ");
  end

  // ==========================================================
  // Declarations
  // ==========================================================
  lbc_state_s st;
  lbc_state_s next_st;

  logic op_is_and;
  logic op_is_clear;
  logic op_known;
  logic in_idle;
  logic accept;

  logic [DATA_W-1:0] and_result;
  logic [DATA_W-1:0] clr_mask;
  logic [DATA_W-1:0] clr_result;
  logic [DATA_W-1:0] result;

  logic res_zero;
  logic res_neg;
  logic and_carry;

  lbc_wr_s wb_word;
  lbc_flags_s flag_word;

  // ==========================================================
  // Opcode decode
  // ==========================================================
  // Any other opcode belongs to another unit and is ignored here
  assign op_is_and = (issue.opcode == OP_AND);
  assign op_is_clear = (issue.opcode == OP_BIT_CLEAR);
  assign op_known = op_is_and || op_is_clear;

  // ==========================================================
  // Issue handshake
  // ==========================================================
  // One instruction at a time: the next waits until the write cycle ends
  assign in_idle = (st.phase == LBC_IDLE);
  assign issue_ready = in_idle;
  assign accept = issue_valid && in_idle && op_known;

  // ==========================================================
  // Register file read request
  // ==========================================================
  // Read data must be valid in this same cycle; there is no read stage
  always_comb begin
    rd_req.src_en = 1'b0;
    rd_req.dst_en = 1'b0;
    rd_req.src_addr = 5'h00;
    rd_req.dst_addr = 5'h00;
    if (accept) begin
      rd_req.dst_en = 1'b1;
      rd_req.dst_addr = issue.dst_field;
      rd_req.src_en = op_is_and;
      rd_req.src_addr = issue.src_field;
    end
  end

  // ==========================================================
  // Per-bit datapath
  // ==========================================================
  // The immediate in the source field selects one bit, index 0..31
  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    assign clr_mask[i] = (st.src_field == IDX_W'(i));
    assign and_result[i] = st.src_val[i] & st.dst_val[i];
    assign clr_result[i] = st.dst_val[i] & ~clr_mask[i];
  end

  // ==========================================================
  // Result select
  // ==========================================================
  always_comb begin
    if (st.is_and) begin
      result = and_result;
    end else begin
      result = clr_result;
    end
  end

  // ==========================================================
  // Flag terms
  // ==========================================================
  assign res_zero = (result == '0);
  assign res_neg = result[SIGN_BIT];
  // Carry looks at the operands as read, not at the result
  assign and_carry = st.dst_val[SIGN_BIT] & st.src_val[SIGN_BIT];

  // ==========================================================
  // Write-back and flag words
  // ==========================================================
  always_comb begin
    wb_word.en = 1'b1;
    wb_word.addr = st.dst_field;
    wb_word.data = result;
    flag_word.z = res_zero;
    flag_word.n = res_neg;
    if (st.is_and) begin
      flag_word.c = and_carry;
    end else begin
      // Bit clear leaves the carry flag at its old value
      flag_word.c = st.flags.c;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Cycle 1 read, cycle 2 execute, cycle 3 write; no overlap, so no bypass
  always_comb begin
    next_st = st;
    next_st.wr.en = 1'b0;
    case (st.phase)
      LBC_IDLE: begin
        if (accept) begin
          next_st.phase = LBC_EXEC;
          next_st.is_and = op_is_and;
          next_st.src_field = issue.src_field;
          next_st.dst_field = issue.dst_field;
          next_st.src_val = rd_src_data;
          next_st.dst_val = rd_dst_data;
        end else begin
          next_st.phase = LBC_IDLE;
        end
      end

      LBC_EXEC: begin
        next_st.phase = LBC_WRITE;
        next_st.wr = wb_word;
        next_st.flags = flag_word;
      end

      LBC_WRITE: begin
        next_st.phase = LBC_IDLE;
      end

      default: begin
        next_st.phase = LBC_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Reset drops an instruction before its write cycle, so it never writes back
  always_ff @(posedge clk) begin
    if (rst) begin
      st.phase <= LBC_IDLE;
      st.is_and <= 1'b0;
      st.src_field <= 5'h00;
      st.dst_field <= 5'h00;
      st.src_val <= 32'h00000000;
      st.dst_val <= 32'h00000000;
      st.wr.en <= 1'b0;
      st.wr.addr <= 5'h00;
      st.wr.data <= 32'h00000000;
      st.flags <= `LBC_FLAGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Data outputs come straight from the state flip-flops
  assign wr = st.wr;
  assign flags = st.flags;
  assign busy = !in_idle;
endmodule
`default_nettype wire

// [tb/lbc_alu_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module lbc_alu_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire lbc_pkg::lbc_instr_s issue,
  input wire logic issue_ready,
  input wire lbc_pkg::lbc_rd_s rd_req,
  input wire logic [31:0] rd_src_data,
  input wire logic [31:0] rd_dst_data,
  input wire lbc_pkg::lbc_wr_s wr,
  input wire lbc_pkg::lbc_flags_s flags,
  input wire logic busy
);
  import lbc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire a = issue.opcode == 6'h09;
  wire t = issue_valid && issue_ready && (a || issue.opcode == 6'h0F);
  // Top bit: expected carry, old flag on bit clear
  wire [32:0] e = a ? {rd_src_data[31] & rd_dst_data[31], rd_src_data & rd_dst_data}
    : {flags.c, rd_dst_data & ~(32'h1 << issue.src_field)};
  AST_D: assert property (t |-> ##2 wr.en && wr.data == $past(e[31:0], 2)) else $error("data");
  AST_C: assert property (t |-> ##2 flags.c == $past(e[32], 2)) else $error("carry");
  AST_Z: assert property (wr.en |-> flags.z == (wr.data == 32'h0)) else $error("zero");
  AST_N: assert property (wr.en |-> flags.n == wr.data[31]) else $error("neg");
  AST_R: assert property (t |-> rd_req.dst_en && rd_req.src_en == a) else $error("read");
  AST_A: assert property (t |-> ##2 wr.addr == $past(issue.dst_field, 2)) else $error("addr");
  AST_P: assert property (wr.en |=> !wr.en) else $error("pulse");
  AST_B: assert property (t |=> !issue_ready [*2] ##1 issue_ready) else $error("ready");
  AST_I: assert property (issue_valid && issue_ready && !t |=> issue_ready && !wr.en) else $error("ignore");
  AST_Q: assert property (!t |-> !rd_req.dst_en && !rd_req.src_en) else $error("no read");
  AST_Y: assert property (busy == !issue_ready) else $error("busy");
  cover property (t && a);
  cover property (t && !a);
  cover property (wr.en && flags.z);
endmodule
bind lbc_alu lbc_alu_asserts u_chk (.*);
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lbc_pkg::*;
  logic clk = 0, rst = 1, issue_valid = 0, issue_ready, busy;
  lbc_instr_s issue = '0;
  logic [31:0] rd_src_data = '0, rd_dst_data = '0;
  lbc_rd_s rd_req;
  lbc_wr_s wr;
  lbc_flags_s flags;
  int n_errors = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  lbc_alu u_lbc_alu (
    .clk(clk),
    .rst(rst),
    .issue_valid(issue_valid),
    .issue(issue),
    .issue_ready(issue_ready),
    .rd_req(rd_req),
    .rd_src_data(rd_src_data),
    .rd_dst_data(rd_dst_data),
    .wr(wr),
    .flags(flags),
    .busy(busy)
  );
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [40:0] s, x);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("FAIL %0t %h", $time, s);
    end
  endtask
  task automatic op(input logic [5:0] o, input logic [4:0] f, input logic [31:0] s, d, r, input logic c);
    @(posedge clk);
    #1 issue_valid = 1;
    issue = '{o, f, 5'h3};
    {rd_src_data, rd_dst_data} = {s, d};
    #5 chk({issue_ready, rd_req}, {1'b1, o == 6'h09, 1'b1, f, 5'h3});
    @(posedge clk);
    #1 issue_valid = 0;
    // Stale read data must not leak into the result
    {rd_src_data, rd_dst_data} = ~{s, d};
    #5 chk({busy, issue_ready}, 2'b10);
    @(posedge clk);
    #1 chk({wr, flags}, {1'b1, 5'h3, r, r == 32'h0, r[31], c});
    chk({busy, issue_ready}, 2'b10);
    @(posedge clk);
    #1 chk({wr.en, busy, issue_ready}, 3'b001);
  endtask
  task automatic t_and;
    op(6'h09, 5'h1, 32'hFFFFFFFF, 32'h80000001, 32'h80000001, 1'b1);
    op(6'h09, 5'h2, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF, 1'b0);
    op(6'h09, 5'h4, 32'h0F0F0F0F, 32'hF0F0F0F0, 32'h0, 1'b0);
  endtask
  task automatic t_bit_clear_op;
    op(6'h0F, 5'h1F, 32'h0, 32'h80000000, 32'h0, 1'b0);
    op(6'h0F, 5'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFE, 1'b0);
  endtask
  task automatic t_carry_keep;
    op(6'h09, 5'h1, 32'hFFFFFFFF, 32'h80000001, 32'h80000001, 1'b1);
    op(6'h0F, 5'h10, 32'hFFFFFFFF, 32'h00010000, 32'h0, 1'b1);
  endtask
  task automatic t_ignore;
    @(posedge clk);
    #1 issue_valid = 1;
    issue = '{6'h0E, 5'h1, 5'h3};
    #5 chk({issue_ready, rd_req}, {1'b1, 12'h000});
    @(posedge clk);
    #1 issue_valid = 0;
    #5 chk({wr.en, busy, issue_ready}, 3'b001);
    @(posedge clk);
    #1 chk({wr.en, busy}, 2'b00);
  endtask
  task automatic t_reset;
    @(posedge clk);
    #1 issue_valid = 1;
    issue = '{6'h09, 5'h1, 5'h3};
    {rd_src_data, rd_dst_data} = {32'hFFFFFFFF, 32'hFFFFFFFF};
    @(posedge clk);
    #1 issue_valid = 0;
    rst = 1;
    @(posedge clk);
    #1 chk({wr, flags, busy, issue_ready}, {38'h0, 3'h0, 1'b0, 1'b1});
    @(posedge clk);
    #1 rst = 0;
    @(posedge clk);
    #1 chk({wr.en, busy, issue_ready}, 3'b001);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    t_and;
    t_bit_clear_op;
    t_carry_keep;
    t_ignore;
    t_reset;
    stop_test;
  end
  initial begin
    #5000;
    n_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
